// file: rtl/fault_led_pkg.sv
// Purpose: Shared constants and types for the fault, warning and notice supervisor
// Assumes: 50 MHz system clock, asynchronous active-high reset
// Notes:   Timing counts derive from times in milliseconds
package fault_led_pkg;

	// Timing in milliseconds and derived cycle counts
	localparam int CLK_HZ          = 50_000_000;
	localparam int LAMP_TEST_MS    = 500;
	localparam int BLINK_ON_MS     = 200;
	localparam int BLINK_OFF_MS    = 200;
	localparam int GROUP_PAUSE_MS  = 1000;
	localparam int ALT_MS          = 250;
	localparam int TICK_MS         = 1;
	localparam int TICK_CYCLES     = (CLK_HZ / 1000) * TICK_MS;
	localparam int LAMP_TEST_TICKS = LAMP_TEST_MS / TICK_MS;
	localparam int BLINK_ON_TICKS  = BLINK_ON_MS / TICK_MS;
	localparam int BLINK_OFF_TICKS = BLINK_OFF_MS / TICK_MS;
	localparam int PAUSE_TICKS     = GROUP_PAUSE_MS / TICK_MS;
	localparam int ALT_TICKS       = ALT_MS / TICK_MS;

	// Blink counts per condition
	localparam logic [2:0] BLINKS_HOT   = 3'h1;
	localparam logic [2:0] BLINKS_LOGHI = 3'h3;
	localparam logic [2:0] BLINKS_LOGLO = 3'h4;
	localparam logic [2:0] BLINKS_MAINH = 3'h5;

	// Temperature thresholds, degrees C, and full current limit
	localparam logic [7:0] TEMP_WARN  = 8'h55;
	localparam logic [7:0] TEMP_FAULT = 8'h64;
	localparam logic [7:0] LIMIT_FULL = 8'hFF;

	// Motor drive response
	typedef enum logic [1:0] {
		DRIVE_RUN,
		DRIVE_LIMIT,
		DRIVE_FREEWHEEL,
		DRIVE_BRAKE
	} drive_t;

	// Raw condition inputs
	typedef struct packed {
		logic estop;
		logic overCurrent;
		logic logicHigh;
		logic logicLow;
		logic mainHighErr;
		logic mainHighWarn;
		logic mainLowWarn;
		logic overVoltage;
	} cond_t;

	// Indicator pattern: red plus two greens
	typedef struct packed {
		logic errorLed;
		logic green_indicator_one;
		logic green_indicator_two;
	} leds_t;

endpackage

// file: rtl/pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for one pin
// Assumes: Single clock domain after the first stage
// Notes:   Output changes only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Pin and filtered level
	input  wire logic pin,
	output var  logic level
);
	logic s1;
	logic s2;
	logic s3;
	logic next_level;

	// First stage feeds only the second
	always_comb begin
		next_level = level;
		if (s2 == s3) begin
			next_level = s3;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1    <= 1'b0;
			s2    <= 1'b0;
			s3    <= 1'b0;
			level <= 1'b0;
		end else begin
			s1    <= pin;
			s2    <= s1;
			s3    <= s2;
			level <= next_level;
		end
	end
endmodule // pin_sync
`default_nettype wire

// file: rtl/fault_led_and_drive_protection.sv
// Purpose: Supervises faults, warnings and notices; drives LEDs, motor response and clamp output
// Assumes: Condition pins asynchronous, temperature word synchronous to clk
// Notes:   Latched errors clear only on reset; display shows most severe condition
`timescale 1ns/1ps
`default_nettype none
module fault_led_and_drive_protection (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// Condition pins
	input  wire fault_led_pkg::cond_t  condPins,
	input  wire logic [7:0]            temperature,
	input  wire logic                  bootMode,
	input  wire logic                  updateDone,
	// Configuration
	input  wire logic                  clampEnable,
	input  wire logic                  clampInvert,
	input  wire logic                  bridgeEnable,
	// Indicators
	output var  fault_led_pkg::leds_t  leds,
	// Motor drive
	output var  fault_led_pkg::drive_t driveOne,
	output var  fault_led_pkg::drive_t driveTwo,
	output var  logic                  channelEnableOne,
	output var  logic                  channelEnableTwo,
	output var  logic                  bridged,
	output var  logic [7:0]            currentLimit,
	output var  logic [8:0]            peakCurrentScale,
	// Digital output
	output var  logic                  clampOut,
	output var  logic                  faultActive
);
	// Synchronised condition levels
	fault_led_pkg::cond_t cond;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_sync
			pin_sync u_sync (
				.clk   (clk),
				.rst   (rst),
				.pin   (condPins[gi]),
				.level (cond[gi])
			);
		end
	endgenerate

	// Millisecond tick divider
	logic [15:0] divCount;
	logic [15:0] next_divCount;
	logic        tick;
	logic        next_tick;

	always_comb begin
		next_tick     = 1'b0;
		next_divCount = divCount + 16'h0001;
		if (divCount == 16'(fault_led_pkg::TICK_CYCLES - 1)) begin
			next_divCount = 16'h0000;
			next_tick     = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			divCount <= 16'h0000;
			tick     <= 1'b0;
		end else begin
			divCount <= next_divCount;
			tick     <= next_tick;
		end
	end

	// Latched errors hold until reset
	logic latchLogHi;
	logic latchLogLo;
	logic latchMainHi;
	logic next_latchLogHi;
	logic next_latchLogLo;
	logic next_latchMainHi;
	logic bootNotice;
	logic next_bootNotice;
	logic bootSeen;
	logic next_bootSeen;

	always_comb begin
		next_latchLogHi  = latchLogHi | cond.logicHigh;
		next_latchLogLo  = latchLogLo | cond.logicLow;
		next_latchMainHi = latchMainHi | cond.mainHighErr;
		// Boot notice caught once after release; update completion clears it
		next_bootSeen   = 1'b1;
		next_bootNotice = bootNotice;
		if (!bootSeen) begin
			next_bootNotice = bootMode;
		end else if (updateDone) begin
			next_bootNotice = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latchLogHi  <= 1'b0;
			latchLogLo  <= 1'b0;
			latchMainHi <= 1'b0;
			bootNotice  <= 1'b0;
			bootSeen    <= 1'b0;
		end else begin
			latchLogHi  <= next_latchLogHi;
			latchLogLo  <= next_latchLogLo;
			latchMainHi <= next_latchMainHi;
			bootNotice  <= next_bootNotice;
			bootSeen    <= next_bootSeen;
		end
	end

	// Classify the present condition by severity
	logic       overHot;
	logic       warmWarn;
	logic       anyFault;
	logic       anyWarn;
	logic [2:0] blinkCount;

	assign overHot  = temperature > fault_led_pkg::TEMP_FAULT;
	assign warmWarn = temperature > fault_led_pkg::TEMP_WARN;
	assign anyFault = cond.estop | overHot | latchLogHi | latchLogLo | latchMainHi;
	assign anyWarn  = warmWarn | cond.overCurrent | cond.mainHighWarn | cond.mainLowWarn;

	// Highest latched code wins; blink count zero means no blink code
	always_comb begin
		blinkCount = 3'h0;
		if (latchMainHi) begin
			blinkCount = fault_led_pkg::BLINKS_MAINH;
		end else if (latchLogLo) begin
			blinkCount = fault_led_pkg::BLINKS_LOGLO;
		end else if (latchLogHi) begin
			blinkCount = fault_led_pkg::BLINKS_LOGHI;
		end else if (overHot) begin
			blinkCount = fault_led_pkg::BLINKS_HOT;
		end
	end

	// Blink sequencer: on, off, repeated, then a group pause
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_ON,
		SEQ_OFF,
		SEQ_PAUSE
	} seq_t;

	seq_t        seqState;
	seq_t        next_seqState;
	logic [10:0] seqTicks;
	logic [10:0] next_seqTicks;
	logic [2:0]  seqDone;
	logic [2:0]  next_seqDone;

	always_comb begin
		next_seqState = seqState;
		next_seqTicks = seqTicks;
		next_seqDone  = seqDone;
		if (blinkCount == 3'h0) begin
			next_seqState = SEQ_IDLE;
		end else if (tick) begin
			next_seqTicks = seqTicks + 11'h001;
			case (seqState)
				SEQ_IDLE: begin
					next_seqState = SEQ_ON;
					next_seqTicks = 11'h000;
					next_seqDone  = 3'h0;
				end
				SEQ_ON: begin
					if (seqTicks >= 11'(fault_led_pkg::BLINK_ON_TICKS - 1)) begin
						next_seqState = SEQ_OFF;
						next_seqTicks = 11'h000;
						next_seqDone  = seqDone + 3'h1;
					end
				end
				SEQ_OFF: begin
					if (seqTicks >= 11'(fault_led_pkg::BLINK_OFF_TICKS - 1)) begin
						next_seqTicks = 11'h000;
						next_seqState = (seqDone >= blinkCount) ? SEQ_PAUSE : SEQ_ON;
					end
				end
				SEQ_PAUSE: begin
					if (seqTicks >= 11'(fault_led_pkg::PAUSE_TICKS - 1)) begin
						next_seqState = SEQ_ON;
						next_seqTicks = 11'h000;
						next_seqDone  = 3'h0;
					end
				end
				default: begin
					next_seqState = SEQ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seqState <= SEQ_IDLE;
			seqTicks <= 11'h000;
			seqDone  <= 3'h0;
		end else begin
			seqState <= next_seqState;
			seqTicks <= next_seqTicks;
			seqDone  <= next_seqDone;
		end
	end

	// Lamp test timer and green alternation timer
	logic [9:0] lampTicks;
	logic [9:0] next_lampTicks;
	logic       lampTest;
	logic [9:0] altTicks;
	logic [9:0] next_altTicks;
	logic       altPhase;
	logic       next_altPhase;

	assign lampTest = lampTicks != 10'(fault_led_pkg::LAMP_TEST_TICKS);

	always_comb begin
		next_lampTicks = lampTicks;
		next_altTicks  = altTicks;
		next_altPhase  = altPhase;
		if (tick && lampTest) begin
			next_lampTicks = lampTicks + 10'h001;
		end
		if (tick) begin
			next_altTicks = altTicks + 10'h001;
			if (altTicks >= 10'(fault_led_pkg::ALT_TICKS - 1)) begin
				next_altTicks = 10'h000;
				next_altPhase = ~altPhase;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lampTicks <= 10'h000;
			altTicks  <= 10'h000;
			altPhase  <= 1'b0;
		end else begin
			lampTicks <= next_lampTicks;
			altTicks  <= next_altTicks;
			altPhase  <= next_altPhase;
		end
	end

	// Indicator pattern, most severe first
	fault_led_pkg::leds_t next_leds;

	always_comb begin
		next_leds = '0;
		if (lampTest) begin
			next_leds = 3'b111;
		end else if (cond.estop) begin
			next_leds = 3'b111;
		end else if (blinkCount != 3'h0) begin
			next_leds.errorLed = (seqState == SEQ_ON);
		end else if (anyWarn) begin
			next_leds.errorLed = 1'b1;
		end else if (bootNotice) begin
			next_leds.green_indicator_one = altPhase;
			next_leds.green_indicator_two = ~altPhase;
		end
	end

	// Drive response; braking outranks freewheel, freewheel outranks limiting
	fault_led_pkg::drive_t next_drive;
	logic [7:0]            next_limit;
	logic [7:0]            derate;

	// Linear derating: sixteen steps of limit per degree above the warning point
	assign derate = (temperature - fault_led_pkg::TEMP_WARN) << 4;

	always_comb begin
		next_drive = fault_led_pkg::DRIVE_RUN;
		next_limit = fault_led_pkg::LIMIT_FULL;
		if (warmWarn) begin
			next_limit = fault_led_pkg::LIMIT_FULL - derate;
			next_drive = fault_led_pkg::DRIVE_LIMIT;
		end
		if (cond.overCurrent) begin
			next_drive = fault_led_pkg::DRIVE_LIMIT;
		end
		if (cond.mainLowWarn) begin
			next_drive = fault_led_pkg::DRIVE_FREEWHEEL;
		end
		if (overHot || latchLogHi || latchLogLo) begin
			next_drive = fault_led_pkg::DRIVE_FREEWHEEL;
		end
		if (cond.mainHighWarn || latchMainHi || cond.estop) begin
			next_drive = fault_led_pkg::DRIVE_BRAKE;
		end
	end

	// Registered outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			leds             <= '0;
			driveOne         <= fault_led_pkg::DRIVE_RUN;
			driveTwo         <= fault_led_pkg::DRIVE_RUN;
			channelEnableOne <= 1'b0;
			channelEnableTwo <= 1'b0;
			bridged          <= 1'b0;
			currentLimit     <= fault_led_pkg::LIMIT_FULL;
			peakCurrentScale <= 9'h0FF;
			clampOut         <= 1'b0;
			faultActive      <= 1'b0;
		end else begin
			leds             <= next_leds;
			driveOne         <= next_drive;
			driveTwo         <= next_drive;
			channelEnableOne <= ~anyFault;
			channelEnableTwo <= ~anyFault;
			bridged          <= bridgeEnable;
			currentLimit     <= next_limit;
			// Bridged channel sees the sum of both peaks
			peakCurrentScale <= bridgeEnable ? {next_limit, 1'b0} : {1'b0, next_limit};
			clampOut         <= (clampEnable & cond.overVoltage) ^ clampInvert;
			faultActive      <= anyFault;
		end
	end
endmodule // fault_led_and_drive_protection
`default_nettype wire

// file: bench/fault_led_checker.sv
// Purpose: Port-level assertions for the fault supervisor
// Assumes: Condition pins pass a synchroniser of about five cycles
// Notes:   Latch flags mirror pins held long enough to be taken
`timescale 1ns/1ps
`default_nettype none
module fault_led_checker (
	// Clock and reset
	input wire logic                  clk,
	input wire logic                  rst,
	// Inputs
	input wire fault_led_pkg::cond_t  condPins,
	input wire logic [7:0]            temperature,
	input wire logic                  clampEnable,
	input wire logic                  clampInvert,
	input wire logic                  bridgeEnable,
	// Outputs
	input wire fault_led_pkg::leds_t  leds,
	input wire fault_led_pkg::drive_t driveOne,
	input wire fault_led_pkg::drive_t driveTwo,
	input wire logic                  channelEnableOne,
	input wire logic                  channelEnableTwo,
	input wire logic                  bridged,
	input wire logic [7:0]            currentLimit,
	input wire logic [8:0]            peakCurrentScale,
	input wire logic                  clampOut,
	input wire logic                  faultActive
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [3:0] runLog, runMh, next_runLog, next_runMh;
	logic       latLog, latMh, next_latLog, next_latMh;
	// Count high cycles, saturating, so a short glitch never arms a latch
	always_comb begin
		next_runLog = (condPins.logicHigh | condPins.logicLow) ? runLog + {3'h0, runLog != 4'h8} : 4'h0;
		next_runMh  = condPins.mainHighErr ? runMh + {3'h0, runMh != 4'h8} : 4'h0;
		next_latLog = latLog | (runLog == 4'h8);
		next_latMh  = latMh | (runMh == 4'h8);
	end
	// Flags clear only on reset, like the latched errors
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{runLog, runMh, latLog, latMh} <= '0;
		end else begin
			{runLog, runMh, latLog, latMh} <= {next_runLog, next_runMh, next_latLog, next_latMh};
		end
	end
	AST_ESTOP: assert property (condPins.estop [*8] |-> driveOne == fault_led_pkg::DRIVE_BRAKE &&
		driveTwo == fault_led_pkg::DRIVE_BRAKE && !channelEnableOne) else $error("estop not braking");
	AST_MAINWARN: assert property (condPins.mainHighWarn [*8] |-> driveOne == fault_led_pkg::DRIVE_BRAKE)
		else $error("main high warning not braking");
	// Sampled reset keeps the release edge out: outputs there still show reset values
	AST_HOT: assert property (!rst && temperature > fault_led_pkg::TEMP_FAULT |=> faultActive &&
		!channelEnableTwo && driveOne inside {fault_led_pkg::DRIVE_FREEWHEEL, fault_led_pkg::DRIVE_BRAKE})
		else $error("hot not freewheel");
	AST_LIMIT: assert property (!rst && temperature > fault_led_pkg::TEMP_WARN |=> currentLimit ==
		fault_led_pkg::LIMIT_FULL - 8'(($past(temperature) - fault_led_pkg::TEMP_WARN) << 4)) else $error("limit wrong");
	AST_LATFW: assert property (latLog |-> faultActive && driveOne != fault_led_pkg::DRIVE_RUN &&
		driveOne != fault_led_pkg::DRIVE_LIMIT) else $error("logic supply latch lost");
	AST_LATBRK: assert property (latMh |-> driveOne == fault_led_pkg::DRIVE_BRAKE && !channelEnableOne)
		else $error("main high latch lost");
	AST_CLAMP: assert property ($stable({condPins.overVoltage, clampEnable, clampInvert}) [*8] |->
		clampOut == ((clampEnable & condPins.overVoltage) ^ clampInvert)) else $error("clamp wrong");
	AST_BRIDGE: assert property ($stable(bridgeEnable) [*3] |-> bridged == bridgeEnable)
		else $error("bridged wrong");
	AST_SCALE: assert property ($stable({bridged, currentLimit}) [*2] |-> peakCurrentScale ==
		(bridged ? {currentLimit, 1'b0} : {1'b0, currentLimit})) else $error("scale wrong");
	// Any fault must also leave both channels stopped, not merely disabled
	AST_FAULTEN: assert property (faultActive |-> !channelEnableOne && !channelEnableTwo && driveTwo == driveOne &&
		driveOne inside {fault_led_pkg::DRIVE_FREEWHEEL, fault_led_pkg::DRIVE_BRAKE})
		else $error("channel enabled in fault");
	AST_LAMP: assert property ($fell(rst) |-> ##1 (leds == 3'h7) [*8]) else $error("lamp test missing");
endmodule // fault_led_checker
bind fault_led_and_drive_protection fault_led_checker chk (.clk(clk), .rst(rst), .condPins(condPins),
	.temperature(temperature), .clampEnable(clampEnable), .clampInvert(clampInvert), .bridgeEnable(bridgeEnable),
	.leds(leds), .driveOne(driveOne), .driveTwo(driveTwo), .channelEnableOne(channelEnableOne),
	.channelEnableTwo(channelEnableTwo), .bridged(bridged), .currentLimit(currentLimit),
	.peakCurrentScale(peakCurrentScale), .clampOut(clampOut), .faultActive(faultActive));
`default_nettype wire

// file: bench/testbench.sv
// Purpose: Self-checking bench for the fault supervisor
// Assumes: Run stays inside the lamp test, so LEDs read all on
// Notes:   Integer model of drive, limit, clamp and latches
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                  clk = 1'b0;
	logic                  rst = 1'b1;
	fault_led_pkg::cond_t  condPins = '0;
	logic [7:0]            temperature = 8'h00;
	logic                  clampEnable = 1'b0, clampInvert = 1'b0, bridgeEnable = 1'b0;
	logic                  bootMode = 1'b0, updateDone = 1'b0;
	fault_led_pkg::leds_t  leds;
	fault_led_pkg::drive_t driveOne, driveTwo;
	logic                  channelEnableOne, channelEnableTwo, bridged, clampOut, faultActive;
	logic [7:0]            currentLimit;
	logic [8:0]            peakCurrentScale;
	logic [31:0]           lfsr = 32'h0000_1887;
	logic [7:0]            temps [6] = '{8'h55, 8'h56, 8'h64, 8'h65, 8'hFF, 8'h00};
	int                    num_errors = 0, total_checks = 0, cycles = 0, latLog = 0, latMh = 0;
	fault_led_and_drive_protection dut (.clk(clk), .rst(rst), .condPins(condPins), .temperature(temperature),
		.bootMode(bootMode), .updateDone(updateDone), .clampEnable(clampEnable), .clampInvert(clampInvert),
		.bridgeEnable(bridgeEnable), .leds(leds), .driveOne(driveOne), .driveTwo(driveTwo),
		.channelEnableOne(channelEnableOne), .channelEnableTwo(channelEnableTwo), .bridged(bridged),
		.currentLimit(currentLimit), .peakCurrentScale(peakCurrentScale), .clampOut(clampOut),
		.faultActive(faultActive));
	// 50 MHz clock
	always #10 clk = ~clk;
	// Hang guard, far above the expected run length
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles > 5000) begin
			num_errors++;
			final_report();
		end
	end
	function automatic logic [31:0] step(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic check(string what, logic [8:0] got, logic [8:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// Model: brake beats freewheel beats limit
	task automatic compare();
		int t, brk, fw, lim, flt, drv, limit;
		t = temperature;
		brk = condPins.estop | condPins.mainHighWarn | latMh;
		fw = (t > 100) | latLog | condPins.mainLowWarn;
		lim = (t > 85) | condPins.overCurrent;
		flt = condPins.estop | (t > 100) | latLog | latMh;
		drv = brk ? 3 : fw ? 2 : lim ? 1 : 0;
		limit = (t > 85) ? (255 - (t - 85) * 16) & 255 : 255;
		check("drives", 9'({driveOne, driveTwo}), 9'(drv * 5));
		check("fault", 9'(faultActive), 9'(flt));
		check("enables", 9'({channelEnableOne, channelEnableTwo}), 9'(flt ? 0 : 3));
		check("limit", 9'(currentLimit), 9'(limit));
		check("scale", peakCurrentScale, 9'(bridgeEnable ? limit * 2 : limit));
		check("bridged", 9'(bridged), 9'(bridgeEnable));
		check("clamp", 9'(clampOut), 9'((clampEnable & condPins.overVoltage) ^ clampInvert));
		check("leds", 9'(leds), 9'h007);
	endtask
	// Hold a setting long enough to clear the synchroniser, then compare
	task automatic apply(fault_led_pkg::cond_t c, logic [7:0] t, logic [4:0] cfg);
		@(posedge clk);
		condPins <= c;
		temperature <= t;
		{clampEnable, clampInvert, bridgeEnable, bootMode, updateDone} <= cfg;
		latLog = latLog | c.logicHigh | c.logicLow;
		latMh = latMh | c.mainHighErr;
		repeat (10) @(posedge clk);
		@(negedge clk);
		compare();
	endtask
	task automatic do_reset();
		@(posedge clk);
		rst <= 1'b1;
		// Five rising edges in reset, counting the one that releases it
		repeat (4) @(posedge clk);
		@(negedge clk);
		check("reset a", 9'({leds, driveOne, driveTwo, channelEnableOne, channelEnableTwo}), 9'h000);
		check("reset b", 9'({faultActive, currentLimit}), 9'h0FF);
		check("reset d", 9'(clampOut), 9'h000);
		check("reset c", peakCurrentScale, 9'h0FF);
		latLog = 0;
		latMh = 0;
		@(posedge clk);
		rst <= 1'b0;
	endtask
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		do_reset();
		foreach (temps[i]) apply('0, temps[i], 5'h08);
		$display("Test temperature bounds done");
		// Each condition alone, then released; latched ones must stay until reset
		for (int i = 0; i < 8; i++) begin
			apply(fault_led_pkg::cond_t'(8'h01 << i), 8'h14, 5'h10);
			apply('0, 8'h14, 5'h08);
			do_reset();
		end
		$display("Test conditions done");
		for (int n = 0; n < 80; n++) begin
			lfsr = step(lfsr);
			apply(fault_led_pkg::cond_t'(lfsr[7:0] & 8'hC7), lfsr[15:8], lfsr[20:16]);
		end
		$display("Test random mix done");
		final_report();
	end
endmodule // testbench
`default_nettype wire
